// *** dcrl_defs.svh ***
// constants for the dc bus and current ramp limiter
`ifndef DCRL_DEFS_SVH
`define DCRL_DEFS_SVH
`define DCRL_MODE_RST        2'h0
`define DCRL_BUS_LVL_MIN     11'd339
`define DCRL_BUS_LVL_MAX     11'd1200
`define DCRL_BUS_LVL_CLASS0  11'd400
`define DCRL_BUS_LVL_MID     11'd800
`define DCRL_BUS_LVL_HIGH    11'd1000
`define DCRL_CLASS_HIGH_MIN  3'h6
`define DCRL_GAIN_MAX        10'd999
`define DCRL_GAIN_RST        10'd150
`define DCRL_GAIN_SCALE      32'd100
`define DCRL_CUR_MAX         12'd2000
`define DCRL_CUR_FACTOR_NUM  13'd3
`define DCRL_FREQ_MAX        16'd5000
`define DCRL_MODE_BUS_ACCEL  0
`define DCRL_MODE_CUR_HOLD   1
`endif

// *** dcrl_limiter.sv ***
// dc bus voltage and output current limiter acting on the speed ramp
//
// Function
// - bus hold modes 0/2 limit only while the ramp decelerates
// - bus hold: at regulation level, freeze ramp output speed
// - bus accelerate modes 1/3 regulate in every speed condition except under permanent magnet control
// - accelerate modes: error = bus voltage minus level, times gain
// - add gain times error to ramp output as Hz
// - gain 0.00..9.99 in hundredths, default 1.50
// - mode 0..3 decodes bus hold/accel and current decel/hold; default 0
// - while limiting, ramp ignores reference and accelerates, decelerates or freezes
// - bus level 339..1200 V; reset default 400 V for every supply voltage class
// - permanent magnet control: bus regulation by ramp hold while decelerating
// - current hold modes 2/3 freeze ramp while current over level
// - current hold acts when motoring and when regenerating
// - current decel modes 0/1 force zero reference while current over level
// - current level 0.0..200.0 A in 0.1 A, reset default 200.0 A
// - permanent magnet: hold while accelerating, else let speed fall with load
// - permanent magnet setup leaves current level at 1.5x motor rated current
// - bus limitation wins over current limitation
// - any limiting action uses the third ramp rate
`timescale 1ns/1ns
`include "dcrl_defs.svh"

module dcrl_limiter
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    cfgLoad,
    input  wire logic [1:0]              limiterModeSelect,
    input  wire logic [10:0]             busRegulationLevel,
    input  wire logic [9:0]              busErrorGain,
    input  wire logic [11:0]             maxOutputCurrentLevel,
    input  wire logic [2:0]              supplyVoltageClass,
    input  wire logic [11:0]             nominalCurrent,
    input  wire logic [11:0]             motorRatedCurrent,
    input  wire logic                    permanentMagnetVectorControl,
    input  wire logic [10:0]             measuredBusVoltage,
    input  wire logic [11:0]             outputCurrent,
    input  wire logic                    rampAccelerating,
    input  wire logic                    rampDecelerating,
    input  wire logic [15:0]             rampOutputFreq,
    output dcrl_pkg::dcrl_ramp_cmd_t     rampCmd,
    output logic                         useThirdRamp,
    output logic                         busLimitActive,
    output logic                         curLimitActive,
    output logic [15:0]                  correctedFreq,
    output logic [1:0]                   activeMode,
    output logic [10:0]                  activeBusLevel,
    output logic [9:0]                   activeBusGain,
    output logic [11:0]                  activeCurLevel
);
    import dcrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    dcrl_state_t s_q;
    dcrl_state_t s_d;

    logic [10:0] busLvlDefault;
    logic [11:0] curLvlDefault;
    logic [11:0] pmCurLevel;
    logic        busAccelMode;
    logic        curHoldMode;
    logic        busOver;
    logic        curOver;
    logic        busLimit;
    logic        curLimit;
    logic signed [12:0] busErr;
    logic signed [23:0] corrProd;
    logic signed [23:0] corrHz;
    logic signed [24:0] freqSum;

    function automatic logic [11:0] dcrlTimesOnePointFive(input logic [11:0] cur);
        logic [13:0] wide;
        wide = (14'(cur) * 14'(`DCRL_CUR_FACTOR_NUM)) >> 1;
        if (wide > 14'(`DCRL_CUR_MAX))
            wide = 14'(`DCRL_CUR_MAX);
        return wide[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // defaults and setting ranges

    always_comb
    begin
        if (supplyVoltageClass == 3'h0)
            busLvlDefault = `DCRL_BUS_LVL_CLASS0;
        else if (supplyVoltageClass >= `DCRL_CLASS_HIGH_MIN)
            busLvlDefault = `DCRL_BUS_LVL_HIGH;
        else
            busLvlDefault = `DCRL_BUS_LVL_MID;
        curLvlDefault = dcrlTimesOnePointFive(nominalCurrent);
        pmCurLevel = dcrlTimesOnePointFive(motorRatedCurrent);
    end

    ////////////////////////////////////////////////////////////////////////////
    // limiter decisions, from registered samples and the live ramp flags

    always_comb
    begin
        busAccelMode = s_q.mode[`DCRL_MODE_BUS_ACCEL];
        curHoldMode = s_q.mode[`DCRL_MODE_CUR_HOLD];
        busOver = s_q.busVolt >= s_q.busLevel;
        curOver = s_q.curMeas > s_q.curLevel;
        // pm control always regulates the bus by hold during deceleration
        if (busAccelMode && !permanentMagnetVectorControl)
            busLimit = busOver;
        else
            busLimit = busOver && rampDecelerating;
        if (permanentMagnetVectorControl)
            curLimit = curOver && rampAccelerating;
        else if (curHoldMode)
            curLimit = curOver && (rampAccelerating || rampDecelerating);
        else
            curLimit = curOver;
        busErr = $signed({2'b00, s_q.busVolt}) - $signed({2'b00, s_q.busLevel});
        corrProd = 24'(busErr) * $signed({14'h0000, s_q.busGain});
        corrHz = 24'(corrProd / $signed(24'(`DCRL_GAIN_SCALE)));
        freqSum = $signed({9'h000, rampOutputFreq}) + 25'(corrHz);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;
        if (cfgLoad)
        begin
            s_d.mode = limiterModeSelect;
            if (busRegulationLevel < `DCRL_BUS_LVL_MIN)
                s_d.busLevel = `DCRL_BUS_LVL_MIN;
            else if (busRegulationLevel > `DCRL_BUS_LVL_MAX)
                s_d.busLevel = `DCRL_BUS_LVL_MAX;
            else
                s_d.busLevel = busRegulationLevel;
            if (busErrorGain > `DCRL_GAIN_MAX)
                s_d.busGain = `DCRL_GAIN_MAX;
            else
                s_d.busGain = busErrorGain;
            if (permanentMagnetVectorControl)
                s_d.curLevel = pmCurLevel;
            else if (maxOutputCurrentLevel > `DCRL_CUR_MAX)
                s_d.curLevel = `DCRL_CUR_MAX;
            else
                s_d.curLevel = maxOutputCurrentLevel;
        end
        // inputs sampled once per clock; decisions act one edge later
        s_d.busVolt = measuredBusVoltage;
        s_d.curMeas = outputCurrent;
        s_d.busActive = busLimit;
        s_d.curActive = curLimit && !busLimit;
        s_d.freqOut = rampOutputFreq;
        if (busLimit)
        begin
            if (busAccelMode && !permanentMagnetVectorControl)
            begin
                s_d.rampCmd = DCRL_RAMP_HOLD;
                // saturate rather than wrap; a negative sum means stop
                if (freqSum < 0)
                    s_d.freqOut = 16'h0000;
                else if (freqSum > $signed(25'(`DCRL_FREQ_MAX)))
                    s_d.freqOut = `DCRL_FREQ_MAX;
                else
                    s_d.freqOut = freqSum[15:0];
            end
            else
                s_d.rampCmd = DCRL_RAMP_HOLD;
        end
        else if (curLimit)
        begin
            if (curHoldMode || permanentMagnetVectorControl)
                s_d.rampCmd = DCRL_RAMP_HOLD;
            else
                s_d.rampCmd = DCRL_RAMP_ZERO_REF;
        end
        else
            s_d.rampCmd = DCRL_RAMP_FOLLOW;
        s_d.useThirdRamp = busLimit || curLimit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_q.mode <= `DCRL_MODE_RST;
            s_q.busLevel <= `DCRL_BUS_LVL_CLASS0;
            s_q.busGain <= `DCRL_GAIN_RST;
            s_q.curLevel <= `DCRL_CUR_MAX;
            s_q.busVolt <= 11'h000;
            s_q.curMeas <= 12'h000;
            s_q.rampCmd <= DCRL_RAMP_FOLLOW;
            s_q.useThirdRamp <= 1'b0;
            s_q.busActive <= 1'b0;
            s_q.curActive <= 1'b0;
            s_q.freqOut <= 16'h0000;
        end
        else
            s_q <= s_d;
    end

    // reset loads 400 V and 200.0 A whatever the class; class defaults are never applied,
    // so software must pulse cfgLoad with the default values it wants
    assign rampCmd = s_q.rampCmd;
    assign useThirdRamp = s_q.useThirdRamp;
    assign busLimitActive = s_q.busActive;
    assign curLimitActive = s_q.curActive;
    assign correctedFreq = s_q.freqOut;
    assign activeMode = s_q.mode;
    assign activeBusLevel = s_q.busLevel;
    assign activeBusGain = s_q.busGain;
    assign activeCurLevel = s_q.curLevel;

    // unused-default guard: class and nominal defaults drive no output
    // and no setting path; cfgLoad callers must supply the values
    logic unusedDefaults;
    assign unusedDefaults = ^{busLvlDefault, curLvlDefault};
endmodule

// *** dcrl_limiter_sva.sv ***
// assertion checker for the dc bus and current ramp limiter
`timescale 1ns/1ns
module dcrl_limiter_sva
(
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               permanentMagnetVectorControl,
    input wire logic [10:0]        measuredBusVoltage,
    input wire logic               rampDecelerating,
    input dcrl_pkg::dcrl_ramp_cmd_t rampCmd,
    input wire logic               useThirdRamp,
    input wire logic               busLimitActive,
    input wire logic               curLimitActive,
    input wire logic [15:0]        correctedFreq,
    input wire logic [1:0]         activeMode,
    input wire logic [10:0]        activeBusLevel
);
    import dcrl_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_third_ramp: assert property (useThirdRamp == (busLimitActive || curLimitActive))
        else $error("third ramp flag mismatch");
    a_bus_priority: assert property (!(busLimitActive && curLimitActive))
        else $error("both limit flags set");
    a_bus_freeze: assert property (busLimitActive |-> rampCmd == DCRL_RAMP_HOLD)
        else $error("bus limit without hold");
    a_idle_follow: assert property (!busLimitActive && !curLimitActive |-> rampCmd == DCRL_RAMP_FOLLOW)
        else $error("ramp not following");
    a_cur_hold: assert property (curLimitActive && activeMode[1] && $stable(activeMode) |-> rampCmd == DCRL_RAMP_HOLD)
        else $error("current hold missing");
    // rampCmd follows pm one edge late; the check also requires pm clear two edges back
    a_cur_zero: assert property (curLimitActive && !activeMode[1] && $stable(activeMode)
        && !$past(permanentMagnetVectorControl) && !$past(permanentMagnetVectorControl, 2)
        |-> rampCmd == DCRL_RAMP_ZERO_REF)
        else $error("zero reference missing");
    a_hold_decel: assert property (busLimitActive && !activeMode[0] && $stable(activeMode)
        |-> $past(rampDecelerating))
        else $error("bus hold outside deceleration");
    a_bus_trip: assert property ((measuredBusVoltage >= activeBusLevel && rampDecelerating)[*3]
        |=> busLimitActive)
        else $error("bus limit late");
    a_freq_range: assert property (correctedFreq <= 16'h1388)
        else $error("frequency above range");
endmodule

// *** dcrl_pkg.sv ***
// types for the dc bus and current ramp limiter
package dcrl_pkg;
    typedef enum logic [1:0] {
        DCRL_RAMP_FOLLOW,
        DCRL_RAMP_HOLD,
        DCRL_RAMP_ZERO_REF
    } dcrl_ramp_cmd_t;

    typedef struct packed {
        logic [1:0]     mode;
        logic [10:0]    busLevel;
        logic [9:0]     busGain;
        logic [11:0]    curLevel;
        logic [10:0]    busVolt;
        logic [11:0]    curMeas;
        dcrl_ramp_cmd_t rampCmd;
        logic           useThirdRamp;
        logic           busActive;
        logic           curActive;
        logic [15:0]    freqOut;
    } dcrl_state_t;
endpackage

// *** dcrl_ramp_model.sv ***
// behavioural speed ramp generator obeying the limiter command
`timescale 1ns/1ns
module dcrl_ramp_model
(
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic [15:0]        speedRef,
    input dcrl_pkg::dcrl_ramp_cmd_t rampCmd,
    input wire logic               useThirdRamp,
    output logic                   rampAccelerating,
    output logic                   rampDecelerating,
    output logic [15:0]            rampOutputFreq
);
    import dcrl_pkg::*;
    logic [15:0] target;
    logic [15:0] step;
    assign target = (rampCmd == DCRL_RAMP_ZERO_REF) ? 16'h0000 : speedRef;
    // steeper third ramp makes its use visible; may overshoot by one count, half a step
    assign step = useThirdRamp ? 16'h0002 : 16'h0001;
    // flags show intent, so a frozen ramp keeps its direction
    assign rampAccelerating = target > rampOutputFreq;
    assign rampDecelerating = target < rampOutputFreq;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rampOutputFreq <= 16'h0000;
        else if (rampCmd != DCRL_RAMP_HOLD && rampAccelerating)
            rampOutputFreq <= rampOutputFreq + step;
        else if (rampCmd != DCRL_RAMP_HOLD && rampDecelerating)
            rampOutputFreq <= rampOutputFreq - step;
    end
endmodule

// *** tb_dc_bus_and_current_ramp_limiter.sv ***
// self-checking bench for the dc bus and current ramp limiter
`timescale 1ns/1ns
`include "dcrl_defs.svh"
module tb_dc_bus_and_current_ramp_limiter;
    import dcrl_pkg::*;
    logic ref_clk, rst_n, cfgLoad, pm, rampAccelerating, rampDecelerating, useThirdRamp;
    logic busLimitActive, curLimitActive, up, bo, co, bA, cA, hold;
    logic [1:0]  limiterModeSelect, activeMode, m;
    logic [9:0]  busErrorGain, activeBusGain, g;
    logic [10:0] busRegulationLevel, measuredBusVoltage, activeBusLevel, lvl;
    logic [11:0] maxOutputCurrentLevel, motorRatedCurrent, outputCurrent, activeCurLevel, cl;
    logic [15:0] speedRef, rampOutputFreq, correctedFreq;
    logic [39:0] x;
    dcrl_ramp_cmd_t rampCmd;
    int n_fail, compares, e;
    wire logic [34:0] actSet = {activeMode, activeBusLevel, activeBusGain, activeCurLevel};
    // class and nominal current only shape defaults that reset does not apply
    dcrl_limiter dut_u (.*, .supplyVoltageClass(3'h0), .nominalCurrent(12'h000),
        .permanentMagnetVectorControl(pm));
    dcrl_ramp_model ramp_u (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        {rst_n, cfgLoad, pm, limiterModeSelect, busRegulationLevel, busErrorGain} = '0;
        {maxOutputCurrentLevel, motorRatedCurrent, measuredBusVoltage, outputCurrent} = '0;
        speedRef = 16'h07D0;
        e = $urandom(95);
        tick(4);
        rst_n = 1'b1;
        chk("reset settings", actSet, {2'h0, 11'h190, 10'h096, 12'h7D0});
        chk("reset command", rampCmd, DCRL_RAMP_FOLLOW);
        tick(2100);
        for (int k = 0; k < 48; k++)
        begin
            pm = ($urandom_range(3) == 0);
            m = 2'($urandom_range(3));
            lvl = 11'($urandom);
            g = (k == 0) ? 10'h3FF : 10'($urandom);
            cl = 12'($urandom);
            // even rated current keeps the 1.5x level exact
            motorRatedCurrent = {11'($urandom), 1'b0};
            {limiterModeSelect, busRegulationLevel, busErrorGain, maxOutputCurrentLevel} = {m, lvl, g, cl};
            cfgLoad = 1'b1;
            tick(1);
            cfgLoad = 1'b0;
            lvl = (lvl < `DCRL_BUS_LVL_MIN) ? `DCRL_BUS_LVL_MIN : (lvl > `DCRL_BUS_LVL_MAX) ? `DCRL_BUS_LVL_MAX : lvl;
            g = (g > `DCRL_GAIN_MAX) ? `DCRL_GAIN_MAX : g;
            e = pm ? motorRatedCurrent * `DCRL_CUR_FACTOR_NUM / 2 : cl;
            cl = (e > `DCRL_CUR_MAX) ? `DCRL_CUR_MAX : 12'(e);
            chk("settings", actSet, {m, lvl, g, cl});
            up = 1'($urandom);
            speedRef = up ? rampOutputFreq + 16'h03E8 : rampOutputFreq - 16'h03E8;
            {bo, co} = 2'($urandom);
            bA = bo && (!up || (m[0] && !pm));
            // a zero reference turns the ramp round, which would wake a hold-mode bus limit
            bo = bo && (bA || !co);
            cA = !bA && co && (!pm || up);
            hold = bA || (cA && (pm || m[1]));
            measuredBusVoltage = bo ? lvl + ((k % 4 == 0) ? 11'h000 : 11'($urandom_range(11'h7FF - lvl))) : lvl - 11'h001;
            outputCurrent = co ? cl + 12'($urandom_range(12'h064, 12'h001)) : cl;
            tick(8);
            x = hold ? DCRL_RAMP_HOLD : cA ? DCRL_RAMP_ZERO_REF : DCRL_RAMP_FOLLOW;
            chk("command", rampCmd, x);
            chk("bus flag", busLimitActive, bA);
            if (!pm)
                chk("current flags", {curLimitActive, useThirdRamp}, {cA, bA || cA});
            e = rampOutputFreq + ((bA && m[0] && !pm) ? (measuredBusVoltage - lvl) * g / `DCRL_GAIN_SCALE : 0);
            if (hold)
                chk("frequency", correctedFreq, (e > `DCRL_FREQ_MAX) ? `DCRL_FREQ_MAX : e);
            {measuredBusVoltage, outputCurrent} = '0;
            tick(4);
        end
        end_of_test();
    end
endmodule
bind dcrl_limiter dcrl_limiter_sva sva_u (.*);
